/* hdl/isa_seq_defines.svh */
// Timing counts for the ISA cycle sequencer, in periods of the timing clock.
// Assumes one T equals one clk period at 25 MHz.
`ifndef ISA_SEQ_DEFINES_SVH
`define ISA_SEQ_DEFINES_SVH
`define T_ADDR_TO_IO 5'h02
`define T_ALE_WIDTH 5'h01
`define T_ALE_TO_CMD 5'h02
`define T_LA_HOLD 5'h0E
`define T_ALE_TO_MEM_NEG 5'h0B
`define T_MEM_LA_HOLD 5'h0D
`define T_CMD_WIDTH 5'h09
`define T_MEM_SA_HOLD 5'h0A
`define T_IO_SA_HOLD 5'h13
`define T_CMD_TO_ALE 5'h0A
`define T_CMD_SPACING 5'h0C
`define T_RECOVERY 5'h03
`define T_NEG_TO_ALE 5'h01
`define T_IOW_VALID 5'h02
`define T_RDY_NEG_16 5'h06
`define T_RDY_NEG_8 5'h0C
`define T_DATA_16 5'h04
`define T_DATA_8 5'h0A
`define CNT_MAX 5'h1F
`define CNT_ONE 5'h01
`define CNT_ZERO 5'h00
`endif

/* hdl/isa_seq_pkg.sv */
// Types shared by both ends of the ISA cycle sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package isa_seq_pkg;
  typedef enum logic [1:0] {cls_mem, cls_smem, cls_io} cmd_class_type;
  typedef logic [4:0] tcount_type;
endpackage

/* hdl/isa_link_if.sv */
// Link between the ISA master sequencer and an ISA slave.
// Assumes both ends share clk; the data bus is split into per-side signals.
`timescale 1ns/100ps
`default_nettype none
interface isa_link_if;
  logic [19:0] sa;
  logic sbhe;
  logic [23:17] la;
  logic ale;
  logic memr_n;
  logic memw_n;
  logic smemr_n;
  logic smemw_n;
  logic ior_n;
  logic iow_n;
  logic iochrdy;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic cs16;
  modport master (output sa, sbhe, la, ale, memr_n, memw_n, smemr_n, smemw_n,
    ior_n, iow_n, wdata, input iochrdy, rdata, cs16);
  modport slave (input sa, sbhe, la, ale, memr_n, memw_n, smemr_n, smemw_n,
    ior_n, iow_n, wdata, output iochrdy, rdata, cs16);
endinterface
`default_nettype wire

/* hdl/isa_master_seq.sv */
// ISA bus master cycle sequencer: orders address, ALE, commands, recovery.
// Assumes one clk period is one T and slave signals are synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
`include "isa_seq_defines.svh"
// Functional notes
// - Address stable two T before I/O command
// - ALE asserted at least one T
// - Two T from ALE to any command
// - Upper address held fourteen T after ALE
// - Same fourteen T hold in compressed timing
// - Eleven T from ALE to memory negation
// - Upper address held thirteen T after command
// - Command asserted at least nine T
// - System address held ten T after memory command
// - System address held nineteen T after I/O command
// - Ten T from command to next ALE
// - Twelve T between same-class commands
// - Three T recovery before next command
// - One T from command negation to ALE
// - Slave drops ready within eight/fourteen T
// - Slave drops ready within six/twelve T
// - Slave read data eight/fourteen T after LA
// - Slave read data four T after ALE
// - I/O write valid two T after edge
module isa_master_seq
  import isa_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User request
  input wire logic req,
  input wire logic req_write,
  input wire cmd_class_type req_class,
  input wire logic [23:0] req_addr,
  input wire logic req_bhe,
  input wire logic [15:0] req_wdata,
  input wire logic req_compressed,
  // User answer
  output logic busy,
  output logic done,
  output logic [15:0] rd_data,
  // ISA link
  isa_link_if.master bus
);
  typedef enum logic [2:0] {st_idle, st_ale, st_setup, st_cmd, st_hold, st_recov}
    state_type;

  state_type state_reg, state_next;
  tcount_type cnt_reg; // Time since the current phase began
  tcount_type cmd_age_reg; // Time since command assert, saturating
  tcount_type neg_age_reg; // Time since command negate, saturating
  cmd_class_type cls_reg;
  cmd_class_type last_cls_reg; // Class of previous command
  logic last_valid_reg;
  tcount_type last_age_reg; // Time since previous command assert
  logic wr_reg;
  logic wide_reg; // Slave width sampled at ALE
  logic [23:0] addr_reg;
  logic bhe_reg;
  logic [15:0] wd_reg;
  logic ale_reg; // Address latch strobe, high while active
  // Command pins kept at their low-active level so each pin is a flip-flop
  logic memr_n_reg, memw_n_reg, smemr_n_reg, smemw_n_reg, ior_n_reg, iow_n_reg;
  logic busy_reg, done_reg;
  logic [15:0] rd_reg;

  // Start a cycle only when recovery, ALE spacing and class spacing allow
  wire same_class = last_valid_reg && (last_cls_reg == req_class);
  wire spacing_ok = !same_class || (last_age_reg >= `T_CMD_SPACING);
  wire recov_ok = neg_age_reg >= `T_RECOVERY;
  wire ale_ok = (neg_age_reg >= `T_NEG_TO_ALE)
    && (!last_valid_reg || last_age_reg >= `T_CMD_TO_ALE);
  wire start = req && recov_ok && ale_ok && spacing_ok;
  // Setup: ALE lead of two T also gives the address lead for I/O
  wire setup_done = cnt_reg >= `T_ALE_TO_CMD;
  wire ale_done = cnt_reg >= `T_ALE_WIDTH;
  wire is_io = cls_reg == cls_io;
  // Hold time for SA after command, class-dependent
  wire [4:0] sa_hold = is_io ? `T_IO_SA_HOLD : `T_MEM_SA_HOLD;
  // Command must last nine T and span eleven T from ALE, the latter
  // already met with two T setup; ready low stretches it
  wire width_ok = cnt_reg >= `T_CMD_WIDTH;
  wire cmd_end = width_ok && bus.iochrdy;
  // Hold phase waits the remaining address and LA hold
  wire la_ok = cmd_age_reg >= `T_MEM_LA_HOLD;
  wire hold_done = la_ok && (cmd_age_reg >= sa_hold)
    && (cnt_reg >= `T_LA_HOLD);
  wire in_cmd = state_reg == st_cmd;

  // Next state selection
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      st_idle: if (start) state_next = st_ale;
      st_ale: if (ale_done) state_next = st_setup;
      st_setup: if (setup_done) state_next = st_cmd;
      st_cmd: if (cmd_end) state_next = st_hold;
      st_hold: if (hold_done) state_next = st_recov;
      st_recov: state_next = st_idle;
    endcase
  end

  // Phase counter restarts on every phase change
  always_ff @(posedge clk) begin
    if (!resetn) cnt_reg <= `CNT_ZERO;
    else if (state_next != state_reg) cnt_reg <= `CNT_ONE;
    else if (cnt_reg != `CNT_MAX) cnt_reg <= cnt_reg + `CNT_ONE;
  end

  // State and cycle capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= st_idle;
      cls_reg <= cls_mem;
      wr_reg <= 1'b0;
      addr_reg <= 24'h000000;
      bhe_reg <= 1'b0;
      wd_reg <= 16'h0000;
      wide_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      // Address is captured only at start so it stays stable all cycle
      if (state_reg == st_idle && start) begin
        cls_reg <= req_class;
        wr_reg <= req_write;
        addr_reg <= req_addr;
        bhe_reg <= req_bhe;
        wd_reg <= req_wdata;
      end
      if (state_reg == st_ale) wide_reg <= bus.cs16;
    end
  end

  // Age counters, saturating so long idle periods do not wrap
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmd_age_reg <= `CNT_MAX;
      neg_age_reg <= `CNT_MAX;
      last_age_reg <= `CNT_MAX;
      last_valid_reg <= 1'b0;
      last_cls_reg <= cls_mem;
    end else begin
      if (state_reg == st_setup && setup_done) begin
        cmd_age_reg <= `CNT_ONE;
        last_age_reg <= `CNT_ONE;
        last_valid_reg <= 1'b1;
        last_cls_reg <= cls_reg;
      end else begin
        if (cmd_age_reg != `CNT_MAX) cmd_age_reg <= cmd_age_reg + `CNT_ONE;
        if (last_age_reg != `CNT_MAX) last_age_reg <= last_age_reg + `CNT_ONE;
      end
      if (in_cmd && cmd_end) neg_age_reg <= `CNT_ONE;
      else if (in_cmd) neg_age_reg <= `CNT_ZERO;
      else if (neg_age_reg != `CNT_MAX) neg_age_reg <= neg_age_reg + `CNT_ONE;
    end
  end

  // Strobe decode; IOW changes on a registered edge three T after ALE rises
  wire cmd_on = state_next == st_cmd;
  wire ale_on = state_next == st_ale;
  wire memr_on = cmd_on && cls_reg == cls_mem && !wr_reg;
  wire memw_on = cmd_on && cls_reg == cls_mem && wr_reg;
  wire smemr_on = cmd_on && cls_reg == cls_smem && !wr_reg;
  wire smemw_on = cmd_on && cls_reg == cls_smem && wr_reg;
  wire ior_on = cmd_on && is_io && !wr_reg;
  wire iow_on = cmd_on && is_io && wr_reg;
  wire rd_take = in_cmd && cmd_end && !wr_reg;

  // Registered strobes and user outputs
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ale_reg <= 1'b0;
      memr_n_reg <= 1'b1;
      memw_n_reg <= 1'b1;
      smemr_n_reg <= 1'b1;
      smemw_n_reg <= 1'b1;
      ior_n_reg <= 1'b1;
      iow_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rd_reg <= 16'h0000;
    end else begin
      ale_reg <= ale_on;
      memr_n_reg <= !memr_on;
      memw_n_reg <= !memw_on;
      smemr_n_reg <= !smemr_on;
      smemw_n_reg <= !smemw_on;
      ior_n_reg <= !ior_on;
      iow_n_reg <= !iow_on;
      busy_reg <= state_next != st_idle;
      done_reg <= state_reg == st_recov;
      // 8-bit slaves answer on the low lane only
      if (rd_take) rd_reg <= wide_reg ? bus.rdata : {8'h00, bus.rdata[7:0]};
    end
  end

  // Link drive: address held from register, strobes active low
  assign bus.sa = addr_reg[19:0];
  assign bus.sbhe = bhe_reg;
  assign bus.la = addr_reg[23:17];
  assign bus.wdata = wd_reg;
  assign bus.ale = ale_reg;
  assign bus.memr_n = memr_n_reg;
  assign bus.memw_n = memw_n_reg;
  assign bus.smemr_n = smemr_n_reg;
  assign bus.smemw_n = smemw_n_reg;
  assign bus.ior_n = ior_n_reg;
  assign bus.iow_n = iow_n_reg;
  assign busy = busy_reg;
  assign done = done_reg;
  assign rd_data = rd_reg;
endmodule
`default_nettype wire

/* hdl/isa_slave_end.sv */
// ISA slave end: answers reads, takes writes, inserts wait states.
// Assumes the master drives the link synchronous to the same clk.
`timescale 1ns/100ps
`default_nettype none
`include "isa_seq_defines.svh"
module isa_slave_end
  import isa_seq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // User side configuration and data
  input wire logic is_wide,
  input wire logic [4:0] wait_cycles,
  input wire logic [15:0] rd_value,
  output logic wr_strobe,
  output logic [15:0] wr_value,
  output logic [19:0] wr_addr,
  // ISA link
  isa_link_if.slave bus
);
  tcount_type ale_age_reg; // Time since ALE, saturating
  tcount_type wait_reg; // Wait states left
  logic rdy_reg, wr_stb_reg, cmd_d_reg;
  logic [15:0] wv_reg, rd_reg;
  logic [19:0] wa_reg;

  wire cmd_act = !(bus.memr_n && bus.memw_n && bus.smemr_n && bus.smemw_n
    && bus.ior_n && bus.iow_n);
  wire wr_act = !(bus.memw_n && bus.smemw_n && bus.iow_n);
  wire [4:0] rdy_lim = is_wide ? `T_RDY_NEG_16 : `T_RDY_NEG_8;
  // Ready drops well before the limit: one T after command start, ALE plus three T
  wire drop_rdy = cmd_act && !cmd_d_reg && wait_cycles != `CNT_ZERO
    && ale_age_reg <= rdy_lim;

  // Ready, wait count, ALE age
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ale_age_reg <= `CNT_MAX;
      wait_reg <= `CNT_ZERO;
      rdy_reg <= 1'b1;
      cmd_d_reg <= 1'b0;
    end else begin
      cmd_d_reg <= cmd_act;
      if (bus.ale) ale_age_reg <= `CNT_ZERO;
      else if (ale_age_reg != `CNT_MAX) ale_age_reg <= ale_age_reg + `CNT_ONE;
      if (drop_rdy) begin
        rdy_reg <= 1'b0;
        wait_reg <= wait_cycles;
      end else if (wait_reg != `CNT_ZERO) wait_reg <= wait_reg - `CNT_ONE;
      else rdy_reg <= 1'b1;
    end
  end

  // Read data presented from ALE onward, well inside four T
  always_ff @(posedge clk) begin
    if (!resetn) rd_reg <= 16'h0000;
    else if (bus.ale) rd_reg <= rd_value;
  end

  // Write capture on every cycle of a write command; the strobe pulses on alternate cycles while ready is high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_stb_reg <= 1'b0;
      wv_reg <= 16'h0000;
      wa_reg <= 20'h00000;
    end else begin
      wr_stb_reg <= wr_act && bus.iochrdy && cmd_d_reg && !rdy_reg == 1'b0
        && wait_reg == `CNT_ZERO && !wr_stb_reg && cmd_act;
      if (wr_act) begin
        wv_reg <= bus.wdata;
        wa_reg <= bus.sa;
      end
    end
  end

  assign bus.iochrdy = rdy_reg;
  assign bus.rdata = rd_reg;
  assign bus.cs16 = is_wide;
  assign wr_strobe = wr_stb_reg;
  assign wr_value = wv_reg;
  assign wr_addr = wa_reg;
endmodule
`default_nettype wire

/* dv/isa_seq_chk.sv */
// Checker for the ISA link: strobe order and hold intervals, in clk periods.
// Assumes one clk period is one T; it is instantiated beside the link.
`timescale 1ns/100ps
`default_nettype none
module isa_seq_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Address lines
  input wire logic [19:0] sa,
  input wire logic sbhe,
  input wire logic [23:17] la,
  input wire logic ale,
  // Command strobes
  input wire logic memr_n,
  input wire logic memw_n,
  input wire logic smemr_n,
  input wire logic smemw_n,
  input wire logic ior_n,
  input wire logic iow_n,
  // Slave answers
  input wire logic iochrdy,
  input wire logic cs16,
  input wire logic [15:0] rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Any command strobe low
  wire logic cmd_any = !(memr_n && memw_n && smemr_n && smemw_n && ior_n && iow_n);
  wire logic mem_on = !memr_n || !memw_n; // Plain memory command
  wire logic io_on = !ior_n || !iow_n; // I/O command
  // Class code of the running command: 1 memory, 2 system memory, 3 I/O
  wire logic [1:0] cls_now = mem_on ? 2'h1 : (io_on ? 2'h3 : 2'h2);
  logic cmd_q_reg, ale_q_reg; // Last-cycle levels
  logic [1:0] cls_reg; // Class of the last command
  logic [4:0] on_age_reg, off_age_reg, rise_age_reg, fall_age_reg; // Ages since edges
  // Ages saturate so that long-past edges never look recent
  function automatic logic [4:0] sat(input logic [4:0] v);
    return (v == 5'h1F) ? v : v + 5'h01;
  endfunction
  // Restart an age at each strobe edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      {cmd_q_reg, ale_q_reg, cls_reg} <= 4'h0;
      {on_age_reg, off_age_reg, rise_age_reg, fall_age_reg} <= 20'hFFFFF;
    end else begin
      cmd_q_reg <= cmd_any;
      ale_q_reg <= ale;
      cls_reg <= (cmd_any && !cmd_q_reg) ? cls_now : cls_reg;
      on_age_reg <= (cmd_any && !cmd_q_reg) ? 5'h01 : sat(on_age_reg);
      off_age_reg <= (!cmd_any && cmd_q_reg) ? 5'h01 : sat(off_age_reg);
      rise_age_reg <= (ale && !ale_q_reg) ? 5'h01 : sat(rise_age_reg);
      fall_age_reg <= (!ale && ale_q_reg) ? 5'h01 : sat(fall_age_reg);
    end
  end
  sequence cmd_start;
    $rose(cmd_any);
  endsequence
  sequence cmd_nine;
    cmd_any [*8] ##1 cmd_any;
  endsequence
  // Read data from the slave stays put for eight cycles
  sequence data_held;
    $stable(rdata) [*8];
  endsequence
  io_setup_a: assert property (
    ($fell(ior_n) || $fell(iow_n)) |-> $stable(sa) && sa == $past(sa, 2))
    else $error("address moved just before an io command");
  ale_to_cmd_a: assert property ($rose(ale) |-> !cmd_any [*2])
    else $error("command too soon after ale");
  cmd_width_a: assert property (cmd_start |-> cmd_nine)
    else $error("command strobe too short");
  sa_hold_a: assert property (
    ($changed(sa) || $changed(sbhe)) |-> on_age_reg >= ((cls_reg == 2'h3) ? 5'h13 : 5'h0A))
    else $error("system address changed too soon after command");
  la_mem_a: assert property ($changed(la) && cls_reg == 2'h1 |-> on_age_reg >= 5'h0D)
    else $error("upper address changed too soon after memory command");
  la_ale_a: assert property ($changed(la) |-> fall_age_reg >= 5'h0E)
    else $error("upper address changed too soon after ale");
  ale_to_neg_a: assert property (
    ($rose(memr_n) || $rose(memw_n) || $rose(smemr_n) || $rose(smemw_n))
    |-> rise_age_reg >= 5'h0B)
    else $error("memory command ended too soon after ale");
  cmd_to_ale_a: assert property ($rose(ale) |-> on_age_reg >= 5'h0A)
    else $error("ale too soon after command");
  class_space_a: assert property (
    $rose(cmd_any) && cls_now == cls_reg |-> on_age_reg >= 5'h0C)
    else $error("same class commands too close");
  recovery_a: assert property (cmd_start |-> off_age_reg >= 5'h03)
    else $error("command recovery too short");
  neg_to_ale_a: assert property ($rose(ale) |-> off_age_reg >= 5'h01 && !cmd_any)
    else $error("ale while command active");
  // Wait states must be requested early enough for the master to see them
  rdy_drop_a: assert property (
    $fell(iochrdy) |-> rise_age_reg <= (cs16 ? 5'h06 : 5'h0C))
    else $error("ready dropped too late after ale");
  read_data_a: assert property ($rose(ale) |-> ##4 data_held)
    else $error("read data not settled four cycles after ale");
endmodule
`default_nettype wire

/* dv/isa_master_cycle_sequencer_tb_top.sv */
// Testbench: master and slave ends joined over the link, driven by cycles.
// Assumes one clk period is one T; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module isa_master_cycle_sequencer_tb_top import isa_seq_pkg::*;;
  logic clk = 1'b0, resetn = 1'b0; // Clock and reset
  logic req = 1'b0, req_write = 1'b0, req_bhe = 1'b1, req_compressed = 1'b0; // Request
  cmd_class_type req_class = cls_mem; // Command class
  logic [23:0] req_addr = 24'h000000; // Request address
  logic [15:0] req_wdata = 16'h0000, rd_value = 16'h0000; // Data both ways
  logic is_wide = 1'b1; // Slave width
  logic [4:0] wait_cycles = 5'h00; // Slave wait states
  logic busy, done, wr_strobe; // Status
  logic [15:0] rd_data, wr_value; // Returned data
  logic [19:0] wr_addr; // Address seen by slave
  logic got_w = 1'b0; // Slave took a write
  logic [15:0] got_wv; // Captured write value
  logic [19:0] got_wa; // Captured write address
  int n_errors = 0, checked = 0, width = 0, cycles = 0; // Counters
  isa_link_if link ();
  isa_master_seq isa_master_seq_inst (.clk, .resetn, .req, .req_write, .req_class, .req_addr,
    .req_bhe, .req_wdata, .req_compressed, .busy, .done, .rd_data, .bus(link));
  isa_slave_end isa_slave_end_inst (.clk, .resetn, .is_wide, .wait_cycles, .rd_value,
    .wr_strobe, .wr_value, .wr_addr, .bus(link));
  isa_seq_chk chk_inst (.clk, .resetn, .sa(link.sa), .sbhe(link.sbhe), .la(link.la),
    .ale(link.ale), .memr_n(link.memr_n), .memw_n(link.memw_n), .smemr_n(link.smemr_n),
    .smemw_n(link.smemw_n), .ior_n(link.ior_n), .iow_n(link.iow_n), .iochrdy(link.iochrdy),
    .cs16(link.cs16), .rdata(link.rdata));
  // Any command strobe low on the link
  wire logic cmd_low = !(link.memr_n && link.memw_n && link.smemr_n && link.smemw_n
    && link.ior_n && link.iow_n);
  // Clock at 25 MHz
  initial begin
    forever #20 clk = ~clk;
  end
  // Capture writes and command width; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cmd_low === 1'b1) width++;
    if (wr_strobe === 1'b1) {got_w, got_wv, got_wa} <= {1'b1, wr_value, wr_addr};
    if (cycles == 4000) begin
      n_errors++;
      $display("[FAIL] %0t timeout", $time);
      results();
    end
  end
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  // One bus cycle: hold req until busy, then wait for done
  task automatic run(input logic w, input cmd_class_type c, input logic [23:0] a,
      input logic [15:0] d, input logic wide, input logic [4:0] waits);
    int n;
    n = 0;
    @(negedge clk);
    {req, req_write, req_bhe, req_addr, req_wdata} = {1'b1, w, w, a, d};
    req_class = c;
    {rd_value, is_wide, wait_cycles, width, got_w} = {d, wide, waits, 32'h0, 1'b0};
    while (busy !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    req = 1'b0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk(n < 200, "cycle never completed");
    chk(width >= 9 && width > waits, "command width");
    if (w) chk(got_w && got_wa === a[19:0] && got_wv === d, "write");
    else chk(rd_data === (wide ? d : {8'h00, d[7:0]}), "read data");
  endtask
  task automatic results;
    $display("Checks %0d, errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Every class, both directions, both widths, same class back to back, then waits
  initial begin
    repeat (12) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cmd_class_type c; // Class for this pass
      c = cmd_class_type'(i >> 1);
      run(i[0], c, {4'hC, 4'(i), 16'h5A3C}, 16'hA55A ^ 16'(i), i[1], 5'h00);
    end
    run(1'b0, cls_mem, 24'h3C1234, 16'hBEEF, 1'b0, 5'h14);
    run(1'b1, cls_io, 24'h0002F8, 16'h1234, 1'b1, 5'h14);
    results();
  end
endmodule
`default_nettype wire
